// ==== common/ieb_pkg.sv ====
// shared constants and types for the interrupt enable bank
package ieb_pkg;

	// ---------------------------------------------------------------
	// geometry and carriers
	// ---------------------------------------------------------------
	localparam int NUM_BANKS = 4;
	localparam int BANK_W    = 16;

	typedef logic [NUM_BANKS-1:0][BANK_W-1:0] ieb_bank_vec_t;

	// captured ahb address phase
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [2:0] index;
	} ieb_aphase_t;

	// ---------------------------------------------------------------
	// register map, byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_INT_ENABLE_BANK1 = 8'h00;
	localparam logic [7:0] OFS_INT_ENABLE_BANK2 = 8'h04;
	localparam logic [7:0] OFS_INT_ENABLE_BANK3 = 8'h08;
	localparam logic [7:0] OFS_INT_ENABLE_BANK4 = 8'h0C;
	localparam logic [7:0] OFS_INT_FLAG_BANK1   = 8'h10;
	localparam logic [7:0] OFS_INT_FLAG_BANK2   = 8'h14;
	localparam logic [7:0] OFS_INT_FLAG_BANK3   = 8'h18;
	localparam logic [7:0] OFS_INT_FLAG_BANK4   = 8'h1C;
	localparam int         MAP_TOP_BIT          = 5;
	localparam logic [15:0] RST_BANK            = 16'h0000;

	// ---------------------------------------------------------------
	// field positions, bank 1
	// ---------------------------------------------------------------
	localparam int BIT_UART_B_TX_EN      = 15;
	localparam int BIT_UART_B_RX_EN      = 14;
	localparam int BIT_EXT_IRQ_B_EN      = 13;
	localparam int BIT_TIMER_FIVE_EN     = 12;
	localparam int BIT_TIMER_FOUR_EN     = 11;
	localparam int BIT_OUT_CMP_FOUR_EN   = 10;
	localparam int BIT_OUT_CMP_THREE_EN  = 9;
	localparam int BIT_DMA_CH_B_DONE_EN  = 8;
	localparam int BIT_IN_CAP_EIGHT_EN   = 7;
	localparam int BIT_IN_CAP_SEVEN_EN   = 6;
	localparam int BIT_EXT_IRQ_A_EN      = 4;
	localparam int BIT_CHANGE_NOTIFY_EN  = 3;
	localparam int BIT_COMPARATOR_EN     = 2;
	localparam int BIT_I2C_MASTER_EVT_EN = 1;
	localparam int BIT_I2C_SLAVE_EVT_EN  = 0;

	// field positions, banks 2 to 4
	localparam int BIT_DMA_CH_D_DONE_EN  = 14;
	localparam int BIT_PAR_MASTER_PORT_EN = 13;
	localparam int BIT_DMA_CH_C_DONE_EN  = 4;
	localparam int BIT_CAN_EVENT_EN      = 3;
	localparam int BIT_CAN_RX_READY_EN   = 2;
	localparam int BIT_SPI_B_EVENT_EN    = 1;
	localparam int BIT_SPI_B_ERROR_EN    = 0;
	localparam int BIT_RTC_CALENDAR_EN   = 14;
	localparam int BIT_DMA_CH_E_DONE_EN  = 13;
	localparam int BIT_CAN_TX_EN         = 6;
	localparam int BIT_DMA_CH_G_DONE_EN  = 5;
	localparam int BIT_DMA_CH_F_DONE_EN  = 4;
	localparam int BIT_CHECKSUM_GEN_EN   = 3;
	localparam int BIT_UART_B_ERROR_EN   = 2;
	localparam int BIT_UART_A_ERROR_EN   = 1;

	// ---------------------------------------------------------------
	// implemented and can-only bit masks
	// ---------------------------------------------------------------
	localparam logic [15:0] IMPL_BANK1 = 16'((1 << BIT_UART_B_TX_EN) | (1 << BIT_UART_B_RX_EN) |
		(1 << BIT_EXT_IRQ_B_EN) | (1 << BIT_TIMER_FIVE_EN) | (1 << BIT_TIMER_FOUR_EN) |
		(1 << BIT_OUT_CMP_FOUR_EN) | (1 << BIT_OUT_CMP_THREE_EN) | (1 << BIT_DMA_CH_B_DONE_EN) |
		(1 << BIT_IN_CAP_EIGHT_EN) | (1 << BIT_IN_CAP_SEVEN_EN) | (1 << BIT_EXT_IRQ_A_EN) |
		(1 << BIT_CHANGE_NOTIFY_EN) | (1 << BIT_COMPARATOR_EN) | (1 << BIT_I2C_MASTER_EVT_EN) |
		(1 << BIT_I2C_SLAVE_EVT_EN));
	localparam logic [15:0] IMPL_BANK2 = 16'((1 << BIT_DMA_CH_D_DONE_EN) | (1 << BIT_PAR_MASTER_PORT_EN) |
		(1 << BIT_DMA_CH_C_DONE_EN) | (1 << BIT_CAN_EVENT_EN) | (1 << BIT_CAN_RX_READY_EN) |
		(1 << BIT_SPI_B_EVENT_EN) | (1 << BIT_SPI_B_ERROR_EN));
	localparam logic [15:0] IMPL_BANK3 = 16'((1 << BIT_RTC_CALENDAR_EN) | (1 << BIT_DMA_CH_E_DONE_EN));
	localparam logic [15:0] IMPL_BANK4 = 16'((1 << BIT_CAN_TX_EN) | (1 << BIT_DMA_CH_G_DONE_EN) |
		(1 << BIT_DMA_CH_F_DONE_EN) | (1 << BIT_CHECKSUM_GEN_EN) | (1 << BIT_UART_B_ERROR_EN) |
		(1 << BIT_UART_A_ERROR_EN));
	localparam logic [15:0] CAN_BANK2  = 16'((1 << BIT_CAN_EVENT_EN) | (1 << BIT_CAN_RX_READY_EN));
	localparam logic [15:0] CAN_BANK4  = 16'(1 << BIT_CAN_TX_EN);
	localparam ieb_bank_vec_t IMPL_MASK = {IMPL_BANK4, IMPL_BANK3, IMPL_BANK2, IMPL_BANK1};
	localparam ieb_bank_vec_t CAN_MASK  = {CAN_BANK4, RST_BANK, CAN_BANK2, RST_BANK};

	// ---------------------------------------------------------------
	// ahb-lite encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage : ieb_pkg

// ==== design/ieb_flag_bank.sv ====
// sticky request flags of one sixteen-bit bank
`timescale 1ns/1ps

module ieb_flag_bank #(
	parameter logic [15:0] IMPL = 16'hFFFF
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// set by sources, cleared by software
	input  wire logic [15:0] set_vec,
	input  wire logic [15:0] clr_vec,
	// flag state
	output logic      [15:0] flag_next,
	output logic      [15:0] flag_q
);

	// ---------------------------------------------------------------
	// one flop per implemented bit
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_bit
			if (IMPL[i]) begin : g_impl
				logic bit_reg;
				// a set in the clearing cycle wins
				assign flag_next[i] = set_vec[i] | (bit_reg & ~clr_vec[i]);
				always_ff @(posedge hclk or negedge hresetn) begin
					if (!hresetn) begin
						bit_reg <= 1'b0;
					end else begin
						bit_reg <= flag_next[i];
					end
				end
				assign flag_q[i] = bit_reg;
			end else begin : g_none
				// absent source reads zero
				assign flag_next[i] = 1'b0;
				assign flag_q[i]    = 1'b0;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> ((flag_q & $past(set_vec & IMPL)) == $past(set_vec & IMPL)))
		else $error("flag lost a request");
	chk_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> ((flag_q & $past(flag_q & ~clr_vec)) == $past(flag_q & ~clr_vec)))
		else $error("flag dropped without a clear");

endmodule : ieb_flag_bank

// ==== design/ieb_top.sv ====
// interrupt enable bank with sticky flags behind an ahb-lite slave
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

// Functional notes
// - enable bit one passes its source's request, zero holds it back
// - unimplemented bits read zero and ignore writes
// - bank1 bits 15..8: uart b tx/rx, ext irq b, timers, compares, dma b
// - bank1 bits 7,6 input captures; bit 5 absent; bits 4..0 listed sources
// - bank2 bits 14,13 dma d and parallel port; bits 4..0 listed sources
// - bank3 bit 14 rtc calendar, bit 13 dma e; rest absent
// - bank4 bits 6..1 can tx, dma g/f, checksum, uart errors; rest absent
// - without can controller the can enables stay disabled
// - each source sets its own flag; flag reads zero otherwise
module ieb_top #(
	parameter int CAN_PRESENT = 1
) (
	// clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// ahb-lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// peripheral requests in, gated requests out
	input  wire ieb_pkg::ieb_bank_vec_t src_req,
	output ieb_pkg::ieb_bank_vec_t     fwd_req,
	output logic                       irq
);

	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	generate
		if (CAN_PRESENT != 0 && CAN_PRESENT != 1) begin : g_bad_param
			$error("CAN_PRESENT must be 0 or 1");
		end
		// decode assumes four sixteen-bit banks behind a three-bit index
		if (ieb_pkg::NUM_BANKS != 4 || ieb_pkg::BANK_W != 16) begin : g_bad_geom
			$error("bank geometry must be four banks of sixteen bits");
		end
	endgenerate

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	// address phase capture
	ieb_pkg::ieb_aphase_t   ap_reg;
	ieb_pkg::ieb_aphase_t   ap_next;
	// enable, flag and forwarding state
	ieb_pkg::ieb_bank_vec_t en_reg;
	ieb_pkg::ieb_bank_vec_t en_next;
	ieb_pkg::ieb_bank_vec_t wmask;
	ieb_pkg::ieb_bank_vec_t clr_vec;
	ieb_pkg::ieb_bank_vec_t flag_q;
	ieb_pkg::ieb_bank_vec_t flag_nx;
	ieb_pkg::ieb_bank_vec_t fwd_reg;
	ieb_pkg::ieb_bank_vec_t fwd_next;
	// registered bus answer and interrupt line
	logic [31:0]            hrdata_reg;
	logic [31:0]            hrdata_next;
	logic                   hreadyout_reg;
	logic                   hresp_reg;
	logic                   irq_reg;
	logic                   irq_next;
	// decode terms
	logic                   a_take;
	logic                   a_mapped;
	logic                   d_write;
	logic                   d_is_flag;
	logic [1:0]             d_bank;
	logic [3:0]             wr_en_bank;
	logic [3:0]             wr_flag_bank;

	// ---------------------------------------------------------------
	// address phase decode
	// ---------------------------------------------------------------
	// only whole-word nonseq transfers are taken; others see okay and no effect
	always_comb begin
		a_take   = hsel && hready && (htrans == ieb_pkg::HTRANS_NONSEQ) && (hsize == ieb_pkg::HSIZE_WORD);
		a_mapped = (haddr[31:ieb_pkg::MAP_TOP_BIT] == '0) && (haddr[1:0] == 2'h0);
		ap_next.valid = a_take && a_mapped;
		ap_next.write = hwrite;
		ap_next.index = haddr[4:2];
	end

	// ---------------------------------------------------------------
	// data phase write strobes
	// ---------------------------------------------------------------
	// index bit 2 picks flag banks, bits 1:0 the bank
	always_comb begin
		d_write   = ap_reg.valid && ap_reg.write;
		d_is_flag = ap_reg.index[2];
		d_bank    = ap_reg.index[1:0];
		for (int k = 0; k < ieb_pkg::NUM_BANKS; k++) begin
			wr_en_bank[k]   = d_write && !d_is_flag && (d_bank == 2'(k));
			wr_flag_bank[k] = d_write && d_is_flag && (d_bank == 2'(k));
		end
	end

	// ---------------------------------------------------------------
	// enable registers
	// ---------------------------------------------------------------
	// writable mask drops absent bits and, without can, the can bits
	always_comb begin
		for (int k = 0; k < ieb_pkg::NUM_BANKS; k++) begin
			if (CAN_PRESENT == 1) begin
				wmask[k] = ieb_pkg::IMPL_MASK[k];
			end else begin
				wmask[k] = ieb_pkg::IMPL_MASK[k] & ~ieb_pkg::CAN_MASK[k];
			end
			if (wr_en_bank[k]) begin
				en_next[k] = hwdata[15:0] & wmask[k];
			end else begin
				en_next[k] = en_reg[k];
			end
		end
	end

	// ---------------------------------------------------------------
	// flag banks, write one to clear
	// ---------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < ieb_pkg::NUM_BANKS; k++) begin
			clr_vec[k] = wr_flag_bank[k] ? hwdata[15:0] : ieb_pkg::RST_BANK;
		end
	end

	genvar b;
	generate
		for (b = 0; b < ieb_pkg::NUM_BANKS; b++) begin : g_bank
			ieb_flag_bank #(
				.IMPL      (ieb_pkg::IMPL_MASK[b])
			) u_flags (
				.hclk      (hclk),
				.hresetn   (hresetn),
				.set_vec   (src_req[b]),
				.clr_vec   (clr_vec[b]),
				.flag_next (flag_nx[b]),
				.flag_q    (flag_q[b])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// gating and interrupt line
	// ---------------------------------------------------------------
	always_comb begin
		fwd_next = flag_q & en_reg;
		irq_next = |fwd_next;
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	// next values are read so a write in the data phase is seen at once
	always_comb begin
		hrdata_next = 32'h0000_0000;
		if (ap_next.valid && !hwrite) begin
			if (haddr[4]) begin
				hrdata_next = {16'h0000, flag_nx[haddr[3:2]]};
			end else begin
				hrdata_next = {16'h0000, en_next[haddr[3:2]]};
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// bus side: captured address phase and the registered answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_reg        <= '0;
			hrdata_reg    <= 32'h0000_0000;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= ieb_pkg::HRESP_OKAY;
		end else begin
			ap_reg        <= ap_next;
			hrdata_reg    <= hrdata_next;
			hreadyout_reg <= 1'b1; // zero wait states
			hresp_reg     <= ieb_pkg::HRESP_OKAY;
		end
	end

	// enable storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_reg <= {ieb_pkg::NUM_BANKS{ieb_pkg::RST_BANK}};
		end else begin
			en_reg <= en_next;
		end
	end

	// gated requests and interrupt line
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fwd_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			fwd_reg <= fwd_next;
			irq_reg <= irq_next;
		end
	end

	// outputs straight from their flops
	assign hrdata    = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp     = hresp_reg;
	assign fwd_req   = fwd_reg;
	assign irq       = irq_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ---------------------------------------------------------------
	// checks: gating and interrupt line
	// ---------------------------------------------------------------
	// forwarded word is last cycle's flag and enable
	chk_fwd_gate: assert property (1'b1 |=> (fwd_reg == ($past(flag_q) & $past(en_reg))))
		else $error("forwarded request not gated by flag and enable");
	// interrupt line agrees with the forwarded word in the same cycle
	chk_irq_level: assert property (irq_reg == (|fwd_reg))
		else $error("irq disagrees with forwarded requests");
	// nothing both pending and enabled leaves the line low next cycle
	chk_irq_quiet: assert property (((flag_q & en_reg) == '0) |=> !irq_reg)
		else $error("irq raised with nothing pending and enabled");
	// a part built without can forwards no can request
	chk_can_off: assert property (CAN_PRESENT == 0 |-> (fwd_reg & ieb_pkg::CAN_MASK) == '0)
		else $error("can request forwarded without can controller");

	// ---------------------------------------------------------------
	// checks: flags
	// ---------------------------------------------------------------
	// a flag rises only after an edge that saw its source request
	chk_flag_cause: assert property (1'b1 |=> ((flag_q & ~$past(flag_q) & ~$past(src_req)) == '0))
		else $error("flag set without a request");
	// a one written to a flag clears it unless its source fired too
	chk_flag_clear: assert property (1'b1 |=> ((flag_q & $past(clr_vec) & ~$past(src_req)) == '0))
		else $error("flag survived a clear");

	// ---------------------------------------------------------------
	// checks: storage and read data
	// ---------------------------------------------------------------
	// absent positions never hold a one
	chk_unimpl_zero: assert property (((en_reg | flag_q) & ~ieb_pkg::IMPL_MASK) == '0)
		else $error("unimplemented bit set");
	// without can the can enables never store a one
	chk_can_store: assert property (CAN_PRESENT == 0 |-> (en_reg & ieb_pkg::CAN_MASK) == '0)
		else $error("can enable stored without can controller");
	// read data phase: upper half and absent bits are zero
	chk_read_zero: assert property (ap_reg.valid && !ap_reg.write |->
		(hrdata[31:16] == 16'h0000) && ((hrdata[15:0] & ~ieb_pkg::IMPL_MASK[d_bank]) == 16'h0000))
		else $error("read shows unimplemented bits");
	// read data phase shows the addressed register
	chk_read_data: assert property (ap_reg.valid && !ap_reg.write |->
		hrdata[15:0] == (d_is_flag ? flag_q[d_bank] : en_reg[d_bank]))
		else $error("read data does not match register");
	// outside a read data phase the bus reads zero
	chk_read_idle: assert property (!(ap_reg.valid && !ap_reg.write) |-> hrdata == 32'h0000_0000)
		else $error("read data outside a read");
	// enables move only on a write
	chk_enable_hold: assert property (wr_en_bank == 4'h0 |=> $stable(en_reg))
		else $error("enable changed without a write");

	// ---------------------------------------------------------------
	// checks: register map per bank
	// ---------------------------------------------------------------
	// a write keeps implemented bits only, can bits only with can
	chk_bank1_map: assert property (wr_en_bank[0] |=>
		en_reg[0] == ($past(hwdata[15:0]) & ieb_pkg::IMPL_BANK1))
		else $error("bank1 write mapped wrongly");
	chk_bank2_map: assert property (wr_en_bank[1] |=>
		en_reg[1] == ($past(hwdata[15:0]) & ieb_pkg::IMPL_BANK2 & (CAN_PRESENT == 1 ? 16'hFFFF : ~ieb_pkg::CAN_BANK2)))
		else $error("bank2 write mapped wrongly");
	chk_bank3_map: assert property (wr_en_bank[2] |=>
		en_reg[2] == ($past(hwdata[15:0]) & ieb_pkg::IMPL_BANK3))
		else $error("bank3 write mapped wrongly");
	chk_bank4_map: assert property (wr_en_bank[3] |=>
		en_reg[3] == ($past(hwdata[15:0]) & ieb_pkg::IMPL_BANK4 & (CAN_PRESENT == 1 ? 16'hFFFF : ~ieb_pkg::CAN_BANK4)))
		else $error("bank4 write mapped wrongly");

	// ---------------------------------------------------------------
	// checks: bus response
	// ---------------------------------------------------------------
	// zero wait states and always okay
	chk_bus_okay: assert property (hreadyout && (hresp == ieb_pkg::HRESP_OKAY))
		else $error("slave stalled or answered error");

	// ---------------------------------------------------------------
	// cover points for the main scenarios
	// ---------------------------------------------------------------
	cov_enable_write: cover property (wr_en_bank[0] ##1 en_reg[0] != 16'h0000);
	cov_irq_rise: cover property ($rose(irq));
	cov_flag_read: cover property (ap_reg.valid && !ap_reg.write && d_is_flag && hrdata != 32'h0000_0000);
	cov_set_and_clear: cover property (|(clr_vec & src_req & ieb_pkg::IMPL_MASK));
	cov_can_blocked: cover property (CAN_PRESENT == 0 && wr_en_bank[1] && (hwdata[15:0] & ieb_pkg::CAN_BANK2) != 16'h0000);

endmodule : ieb_top

// ==== verif/ieb_src_model.sv ====
// peripheral source model: drives request pulses into the enable bank
`timescale 1ns/1ps

module ieb_src_model (
	// clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// pulse command from the bench
	input  wire logic                   fire,
	input  wire ieb_pkg::ieb_bank_vec_t pattern,
	// request lines into the bank
	output ieb_pkg::ieb_bank_vec_t      src_req
);
	// requests are pulses; lines idle low so a stale level never looks like a new event
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_req <= '0;
		end else begin
			src_req <= fire ? pattern : '0;
		end
	end
endmodule : ieb_src_model

// ==== verif/ieb_top_tb_top.sv ====
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module ieb_top_tb_top;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic                   hclk = 1'b0;
	logic                   hresetn;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [2:0]             hsize;
	logic [31:0]            hwdata;
	wire  logic             hready;
	logic                   hready_nc;
	logic [31:0]            hrdata;
	logic [31:0]            hrdata_nc;
	logic                   hresp;
	logic                   hresp_nc;
	logic                   irq;
	logic                   irq_nc;
	logic                   fire;
	ieb_pkg::ieb_bank_vec_t pattern;
	ieb_pkg::ieb_bank_vec_t src_req;
	ieb_pkg::ieb_bank_vec_t fwd_req;
	ieb_pkg::ieb_bank_vec_t fwd_req_nc;
	ieb_pkg::ieb_bank_vec_t en_m;
	ieb_pkg::ieb_bank_vec_t en_nc_m;
	ieb_pkg::ieb_bank_vec_t flag_m;
	logic [31:0]            rd;
	logic [31:0]            rd_nc;
	int                     n_mismatch;
	int                     total_checks;
	int                     seed;

	// 40 mhz clock
	always #12.5 hclk = ~hclk;

	// ---------------------------------------------------------------
	// design with and without the can controller, plus the sources
	// ---------------------------------------------------------------
	ieb_top #(.CAN_PRESENT(1)) u_ieb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .src_req(src_req), .fwd_req(fwd_req), .irq(irq));
	ieb_top #(.CAN_PRESENT(0)) u_ieb_top_nocan (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata_nc),
		.hreadyout(hready_nc), .hresp(hresp_nc), .src_req(src_req), .fwd_req(fwd_req_nc), .irq(irq_nc));
	ieb_src_model u_ieb_src_model (.hclk(hclk), .hresetn(hresetn), .fire(fire), .pattern(pattern),
		.src_req(src_req));

	// ---------------------------------------------------------------
	// closing, bus and expectation helpers
	// ---------------------------------------------------------------
	task automatic final_report;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// bounded wait for hready high at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		if (hready !== 1'b1) begin
			n_mismatch++;
			final_report();
		end
	endtask : wait_ready

	// one single word transfer; read data of both instances taken at the data phase edge
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		hsize  <= ieb_pkg::HSIZE_WORD;
		htrans <= ieb_pkg::HTRANS_NONSEQ;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd    = hrdata;
		rd_nc = hrdata_nc;
		`CHK("hresp", ieb_pkg::HRESP_OKAY, hresp)
		`CHK("hresp no can", ieb_pkg::HRESP_OKAY, hresp_nc)
		`CHK("hready no can", 1'b1, hready_nc)
	endtask : xfer

	// stored enable value: implemented bits only, can bits dropped when absent
	function automatic logic [15:0] en_exp(input int b, input logic [15:0] d, input logic can);
		return d & ieb_pkg::IMPL_MASK[b] & (can ? 16'hFFFF : ~ieb_pkg::CAN_MASK[b]);
	endfunction : en_exp

	task automatic wr_en(input int b, input logic [31:0] d);
		xfer(32'(b * 4), 1'b1, d);
		en_m[b]    = en_exp(b, d[15:0], 1'b1);
		en_nc_m[b] = en_exp(b, d[15:0], 1'b0);
	endtask : wr_en

	task automatic chk_en(input int b);
		xfer(32'(b * 4), 1'b0, 32'h0);
		`CHK("enable bank", {16'h0000, en_m[b]}, rd)
		`CHK("enable bank no can", {16'h0000, en_nc_m[b]}, rd_nc)
	endtask : chk_en

	task automatic chk_flag(input int b);
		xfer(32'(16 + b * 4), 1'b0, 32'h0);
		`CHK("flag bank", {16'h0000, flag_m[b]}, rd)
		`CHK("flag bank no can", {16'h0000, flag_m[b]}, rd_nc)
	endtask : chk_flag

	// forwarded word lags an enable or flag change by one edge; two edges are waited
	task automatic chk_fwd;
		repeat (2) @(posedge hclk);
		`CHK("fwd_req", flag_m & en_m, fwd_req)
		`CHK("fwd_req no can", flag_m & en_nc_m, fwd_req_nc)
		`CHK("irq", |(flag_m & en_m), irq)
		`CHK("irq no can", |(flag_m & en_nc_m), irq_nc)
	endtask : chk_fwd

	// pulse sources, then let flag and forward stages settle
	task automatic fire_src(input ieb_pkg::ieb_bank_vec_t v);
		fire    <= 1'b1;
		pattern <= v;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (3) @(posedge hclk);
		flag_m = flag_m | (v & ieb_pkg::IMPL_MASK);
		chk_fwd();
	endtask : fire_src

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'h0;
		hwrite  = 1'b0;
		hsize   = 3'h0;
		hwdata  = 32'h0;
		fire    = 1'b0;
		pattern = '0;
		en_m    = '0;
		en_nc_m = '0;
		flag_m  = '0;
		n_mismatch   = 0;
		total_checks = 0;
		seed         = 32'h5498;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset state of every bank
		for (int b = 0; b < 4; b++) begin
			chk_en(b);
			chk_flag(b);
		end
		chk_fwd();
		// all ones then all zeros, read back to back
		for (int b = 0; b < 4; b++) begin
			wr_en(b, 32'hFFFF_FFFF);
			chk_en(b);
			wr_en(b, 32'h0);
			chk_en(b);
		end
		// an unmapped place reads zero; unmapped and misaligned writes are ignored
		xfer(32'h0000_0020, 1'b1, 32'hFFFF_FFFF);
		xfer(32'h0000_0020, 1'b0, 32'h0);
		`CHK("unmapped read", 32'h0, rd)
		xfer(32'h0000_0002, 1'b1, 32'hFFFF_FFFF);
		chk_en(0);
		// random enable traffic
		for (int i = 0; i < 24; i++) begin
			wr_en($random(seed) & 3, $random(seed));
			chk_en($random(seed) & 3);
		end
		// every source at once, unimplemented ones included
		fire_src({4{16'hFFFF}});
		for (int b = 0; b < 4; b++) begin
			chk_flag(b);
			wr_en(b, 32'hFFFF);
		end
		chk_fwd();
		// mask all, then clear flags by writing ones
		for (int b = 0; b < 4; b++) begin
			wr_en(b, 32'h0);
		end
		chk_fwd();
		for (int b = 0; b < 4; b++) begin
			xfer(32'(16 + b * 4), 1'b1, 32'hFFFF);
			flag_m[b] = 16'h0000;
			chk_flag(b);
		end
		// random raise, mask, unmask and clear rounds
		for (int r = 0; r < 10; r++) begin
			for (int b = 0; b < 4; b++) begin
				wr_en(b, $random(seed));
			end
			fire_src({$random(seed), $random(seed)});
			wr_en(r & 3, 32'h0);
			chk_fwd();
			wr_en(r & 3, 32'hFFFF);
			chk_fwd();
			for (int b = 0; b < 4; b++) begin
				chk_flag(b);
				xfer(32'(16 + b * 4), 1'b1, {16'h0000, 16'($random(seed))} | {16'h0000, flag_m[b]});
				flag_m[b] = 16'h0000;
			end
			repeat (2) @(posedge hclk);
			chk_fwd();
		end
		final_report();
	end
endmodule : ieb_top_tb_top
